// file: dv/adc_status_and_cal_access_tb.sv
/*
 * Self-checking bench for the status word and coefficient access logic.
 * Assumes the host model in ascal_host and short calibration step counts.
 */
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %0t mismatch got %h exp %h", $time, (g), (e)); end end
module adc_status_and_cal_access_tb;
    logic                  clk_sys = 1'b0;
    logic                  sys_rst = 1'b1;
    logic [13:0]           cal_coef_in = 14'h1ABC;
    logic [15:0]           rd_data;
    logic                  busy;
    logic [1:0]            power_mgmt;
    logic                  input_range_sel;
    logic [13:0]           gain_coef;
    logic [13:0]           offset_coef;
    ascal_pkg::ascal_req_t req;
    int                    n_errors = 0;
    int                    samples_checked = 0;

    always #20 clk_sys = ~clk_sys;

    ascal_regs #(.CONV_CYCLES(2), .CAL_STEP_CYCLES(8)) u_ascal_regs (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .req(req), .rd_data(rd_data),
        .conv_data(12'h5A5), .cal_coef_in(cal_coef_in), .busy(busy),
        .power_mgmt(power_mgmt), .input_range_sel(input_range_sel),
        .gain_coef(gain_coef), .offset_coef(offset_coef));

    ascal_host u_ascal_host (.clk_sys(clk_sys), .rd_data(rd_data), .req(req));

    // ============================================================
    // Helpers
    // ============================================================
    task automatic rdchk(input logic [1:0] a, input logic [15:0] e);
        logic [15:0] d;
        u_ascal_host.rd(a, d);
        `CHK(d, e)
    endtask

    task automatic report_and_stop();
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ============================================================
    // Scenarios
    // ============================================================
    task automatic t_status();
        `CHK(gain_coef, ascal_pkg::GAIN_RST)
        `CHK(busy, 1'b0)
        u_ascal_host.wr(2'h0, 16'h00C0);
        rdchk(2'h0, 16'h00C0);
        u_ascal_host.wr(2'h0, 16'hC3EC);
        rdchk(2'h0, 16'h03EC);
        `CHK(power_mgmt, 2'h3)
        `CHK(input_range_sel, 1'b1)
        u_ascal_host.wr(2'h1, 16'hFFFF);
        rdchk(2'h0, 16'h03EC);
        $display("test status done");
    endtask

    task automatic t_full();
        u_ascal_host.wr(2'h0, 16'h0000);
        for (int i = 0; i < 10; i++)
            u_ascal_host.wr(2'h1, 16'hC100 + 16'(i));
        `CHK(gain_coef, 14'h0100)
        `CHK(offset_coef, 14'h0101)
        u_ascal_host.wr(2'h0, 16'h0080);
        for (int i = 0; i < 11; i++)
            rdchk(2'h0, 16'h0100 + 16'(i % 10));
        $display("test full sequence done");
    endtask

    task automatic t_subsets();
        u_ascal_host.wr(2'h0, 16'h0002);
        u_ascal_host.wr(2'h1, 16'h0AAA);
        u_ascal_host.wr(2'h1, 16'h0BBB);
        `CHK({gain_coef, offset_coef}, {14'h0AAA, 14'h0BBB})
        u_ascal_host.wr(2'h0, 16'h0004);
        u_ascal_host.wr(2'h1, 16'h0CCC);
        `CHK({gain_coef, offset_coef}, {14'h0AAA, 14'h0CCC})
        u_ascal_host.wr(2'h0, 16'h0006);
        u_ascal_host.wr(2'h1, 16'h0DDD);
        u_ascal_host.wr(2'h1, 16'h0EEE);
        `CHK({gain_coef, offset_coef}, {14'h0EEE, 14'h0CCC})
        u_ascal_host.wr(2'h0, 16'h0086);
        rdchk(2'h0, 16'h0EEE);
        rdchk(2'h0, 16'h0EEE);
        u_ascal_host.wr(2'h0, 16'h0084);
        rdchk(2'h0, 16'h0CCC);
        $display("test subsets done");
    endtask

    task automatic t_abort();
        u_ascal_host.wr(2'h0, 16'h0000);
        u_ascal_host.wr(2'h1, 16'h0111);
        u_ascal_host.wr(2'h1, 16'h0222);
        u_ascal_host.wr(2'h0, 16'h0000);
        u_ascal_host.wr(2'h1, 16'h0333);
        `CHK({gain_coef, offset_coef}, {14'h0333, 14'h0222})
        $display("test abort done");
    endtask

    task automatic t_conv();
        u_ascal_host.wr(2'h0, 16'h0010);
        @(negedge clk_sys);
        `CHK(busy, 1'b1)
        rdchk(2'h0, 16'h05A5);
        `CHK(busy, 1'b0)
        $display("test conversion done");
    endtask

    task automatic t_reset();
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(negedge clk_sys);
        `CHK({gain_coef, offset_coef}, {ascal_pkg::GAIN_RST, ascal_pkg::OFS_RST})
        `CHK({busy, power_mgmt}, 3'h0)
        u_ascal_host.wr(2'h1, 16'h0777);
        `CHK(gain_coef, 14'h0777)
        $display("test reset done");
    endtask

    task automatic t_cal();
        int n;
        u_ascal_host.wr(2'h0, 16'h0004);
        u_ascal_host.wr(2'h0, 16'h00C7);
        rdchk(2'h0, 16'h00D7);
        `CHK(busy, 1'b1)
        u_ascal_host.wr(2'h1, 16'h0555);
        n = 0;
        while (busy !== 1'b0 && n < 200)
        begin
            @(posedge clk_sys);
            n++;
        end
        if (busy !== 1'b0)
        begin
            n_errors++;
            $display("ERROR %0t calibration never finished", $time);
            report_and_stop();
        end
        else
        begin
            `CHK(gain_coef, 14'h1ABC)
            `CHK(offset_coef, ascal_pkg::OFS_RST)
            rdchk(2'h0, 16'h00C6);
            $display("test calibration done");
        end
    endtask

    initial
    begin
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_status();
        t_full();
        t_subsets();
        t_abort();
        t_conv();
        t_reset();
        t_cal();
        report_and_stop();
    end
endmodule

// file: dv/ascal_host.sv
/*
 * Host processor model that drives the register port of the status and
 * calibration-coefficient block.
 * Assumes one system clock; strobes are one cycle and change after an edge.
 */
`timescale 1ns/10ps
module ascal_host (
    input  wire logic             clk_sys,
    input  wire logic [15:0]      rd_data,
    output ascal_pkg::ascal_req_t req
);
    initial req = '0;

    // ============================================================
    // Bus cycles
    // ============================================================
    // Reads and writes are never issued together.
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        req.wr <= 1'b0;
        // Returning mid-cycle lets the caller see what the write stored.
        @(negedge clk_sys);
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [1:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        req.rd <= 1'b0;
        @(negedge clk_sys);
        d = rd_data;
    endtask
endmodule

// file: hw/ascal_pkg.sv
/*
 * Constants, field layouts and types shared by the converter status and
 * calibration-coefficient access block.
 * Assumes a single system clock and a plain strobe-style register port.
 */
package ascal_pkg;

    // ============================================================
    // Register port addresses
    // ============================================================
    localparam int         ADDR_W          = 2;
    localparam logic [1:0] ADDR_CTRL       = 2'h0;
    localparam logic [1:0] ADDR_CAL_WR     = 2'h1;
    localparam logic [1:0] ADDR_CTRL_RB    = 2'h1;
    localparam int         DATA_W          = 16;

    // ============================================================
    // Read-select codes
    // ============================================================
    localparam logic [1:0] RDSEL_RESULT    = 2'h0;
    localparam logic [1:0] RDSEL_RESULT2   = 2'h1;
    localparam logic [1:0] RDSEL_CAL       = 2'h2;
    localparam logic [1:0] RDSEL_STATUS    = 2'h3;

    // ============================================================
    // Calibration-select codes and coefficient index map
    // ============================================================
    localparam logic [1:0] CALSEL_ALL      = 2'h0;
    localparam logic [1:0] CALSEL_GAIN_OFS = 2'h1;
    localparam logic [1:0] CALSEL_OFS      = 2'h2;
    localparam logic [1:0] CALSEL_GAIN     = 2'h3;
    localparam int         PTR_W           = 4;
    localparam int         NUM_COEF        = 10;
    localparam logic [3:0] IDX_GAIN        = 4'h0;
    localparam logic [3:0] IDX_OFS         = 4'h1;
    localparam logic [3:0] IDX_DAC_LAST    = 4'h9;
    localparam int         COEF_W          = 14;
    localparam logic [13:0] GAIN_RST       = 14'h2000;
    localparam logic [13:0] OFS_RST        = 14'h2000;
    localparam logic [13:0] DAC_RST        = 14'h0000;

    // ============================================================
    // Status word layout
    // ============================================================
    localparam int          ST_PMGT_LSB    = 8;
    localparam int          ST_ONES_LSB    = 6;
    localparam int          ST_RANGE       = 5;
    localparam int          ST_BUSY        = 4;
    localparam int          ST_CALKIND     = 3;
    localparam int          ST_CALSEL_LSB  = 1;
    localparam int          ST_CALGO       = 0;
    localparam logic [15:0] STATUS_RST     = 16'h0000;
    localparam logic [15:0] CTRL_RST       = 16'h0000;

    // ============================================================
    // Timing counts in system clock cycles
    // ============================================================
    localparam int CONV_CYCLES     = 17;
    localparam int CAL_STEP_CYCLES = 16;

    // Control register as written by software.
    typedef struct packed {
        logic [1:0] unused_hi;
        logic [3:0] zero;
        logic [1:0] power_mgmt;
        logic [1:0] read_select;
        logic       input_range_sel;
        logic       conv_go;
        logic       cal_kind_sel;
        logic [1:0] cal_select;
        logic       cal_go;
    } ascal_ctrl_t;

    // Register port request.
    typedef struct packed {
        logic [1:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } ascal_req_t;

endpackage

// file: hw/ascal_regs.sv
/*
 * Control register, read-only status word, ten calibration coefficients with
 * an auto-incrementing access pointer, and a simple conversion and
 * calibration sequencer that drives the busy indications.
 * Assumes the register port master runs on clk_sys, issues one-cycle strobes
 * and never asserts read and write together.
 */
`timescale 1ns/10ps

// How it works
// - Status word is sixteen bits, read only.
// - Status word clears to zero at reset.
// - Status bits 15..10 read zero.
// - Status bits 7 and 6 read one.
// - Status bits 9..8 echo power management.
// - Status bit 5 shows input range.
// - Status bit 4 shows conversion or calibration busy.
// - Status bit 3 shows calibration kind.
// - Status bit 0 high while calibrating.
// - Status bits 2..1 show calibration select.
// - Ten host-accessible coefficients: gain, offset, eight DAC.
// - Calibration runs load coefficients automatically.
// - Select picks all, gain+offset, offset, or gain.
// - Same select governs reads and writes.
// - Pointer restarts on control write or sequence end.
// - Pointer starts at gain, except offset-only.
// - Pointer advances after each access in multi-sets.
// - Abandoned sequence restarts on next control write.
// - Coefficient reads carry two leading zeros.
// - Select addresses coefficients only when start bit low.
module ascal_regs #(
    parameter int CONV_CYCLES     = ascal_pkg::CONV_CYCLES,
    parameter int CAL_STEP_CYCLES = ascal_pkg::CAL_STEP_CYCLES
) (
    input  wire logic                clk_sys,
    input  wire logic                sys_rst,
    input  wire ascal_pkg::ascal_req_t req,
    output logic [15:0]              rd_data,
    input  wire logic [11:0]         conv_data,
    input  wire logic [13:0]         cal_coef_in,
    output logic                     busy,
    output logic [1:0]               power_mgmt,
    output logic                     input_range_sel,
    output logic [13:0]              gain_coef,
    output logic [13:0]              offset_coef
);

    // ============================================================
    // Pointer helpers
    // ============================================================
    function automatic logic [3:0] ptr_start(input logic [1:0] sel);
        ptr_start = (sel == ascal_pkg::CALSEL_OFS) ? ascal_pkg::IDX_OFS
                                                   : ascal_pkg::IDX_GAIN;
    endfunction

    function automatic logic [3:0] ptr_last(input logic [1:0] sel);
        case (sel)
            ascal_pkg::CALSEL_ALL:      ptr_last = ascal_pkg::IDX_DAC_LAST;
            ascal_pkg::CALSEL_GAIN_OFS: ptr_last = ascal_pkg::IDX_OFS;
            ascal_pkg::CALSEL_OFS:      ptr_last = ascal_pkg::IDX_OFS;
            default:                    ptr_last = ascal_pkg::IDX_GAIN;
        endcase
    endfunction

    function automatic logic [3:0] ptr_step(input logic [3:0] ptr, input logic [1:0] sel);
        ptr_step = (ptr == ptr_last(sel)) ? ptr_start(sel) : ptr + 4'h1;
    endfunction

    function automatic logic [13:0] cal_cov_fix(input logic [13:0] v);
        cal_cov_fix = v;
    endfunction

    typedef enum logic [0:0] {ASCAL_IDLE, ASCAL_RUN} ascal_state_t;

    ascal_pkg::ascal_ctrl_t ctrl_reg;
    ascal_pkg::ascal_ctrl_t wr_ctrl;
    logic [15:0]            status_reg;
    logic [15:0]            status_next;
    logic [15:0]            rd_data_reg;
    logic [11:0]            result_reg;
    logic [3:0]             ptr_reg;
    logic [1:0]             addr_sel_reg;
    logic [13:0]            coef_reg [ascal_pkg::NUM_COEF];
    ascal_state_t           cal_state_reg;
    logic [1:0]             cal_set_reg;
    logic [3:0]             cal_idx_reg;
    logic [7:0]             cal_cnt_reg;
    logic                   conv_busy_reg;
    logic [7:0]             conv_cnt_reg;
    logic                   ctrl_wr;
    logic                   cal_wr;
    logic                   cal_rd;
    logic                   cal_busy;
    logic                   cal_step;
    logic                   cal_end;
    logic                   conv_done;

    assign wr_ctrl   = ascal_pkg::ascal_ctrl_t'(req.wdata);
    assign ctrl_wr   = req.wr && (req.addr == ascal_pkg::ADDR_CTRL);
    assign cal_wr    = req.wr && (req.addr == ascal_pkg::ADDR_CAL_WR) && !cal_busy;
    assign cal_rd    = req.rd && (req.addr == ascal_pkg::ADDR_CTRL)
                       && (ctrl_reg.read_select == ascal_pkg::RDSEL_CAL) && !cal_busy;
    assign cal_busy  = (cal_state_reg == ASCAL_RUN);
    assign cal_step  = cal_busy && (cal_cnt_reg == 8'(CAL_STEP_CYCLES - 1));
    assign cal_end   = cal_step && (cal_idx_reg == ptr_last(cal_set_reg));
    assign conv_done = conv_busy_reg && (conv_cnt_reg == 8'(CONV_CYCLES - 1));

    // ============================================================
    // Control register
    // ============================================================
    // A host write wins over the hardware clearing of the start bits.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            ctrl_reg <= ascal_pkg::ascal_ctrl_t'(ascal_pkg::CTRL_RST);
        else if (ctrl_wr)
            ctrl_reg <= wr_ctrl;
        else
        begin
            if (cal_end)
                ctrl_reg.cal_go <= 1'b0;
            if (conv_done)
                ctrl_reg.conv_go <= 1'b0;
        end
    end

    // ============================================================
    // Status word
    // ============================================================
    always_comb
    begin
        status_next                                      = 16'h0000;
        status_next[ascal_pkg::ST_PMGT_LSB +: 2]         = ctrl_reg.power_mgmt;
        status_next[ascal_pkg::ST_ONES_LSB +: 2]         = 2'h3;
        status_next[ascal_pkg::ST_RANGE]                 = ctrl_reg.input_range_sel;
        status_next[ascal_pkg::ST_BUSY]                  = conv_busy_reg | cal_busy;
        status_next[ascal_pkg::ST_CALKIND]               = ctrl_reg.cal_kind_sel;
        status_next[ascal_pkg::ST_CALSEL_LSB +: 2]       = ctrl_reg.cal_select;
        status_next[ascal_pkg::ST_CALGO]                 = cal_busy;
    end

    // Only hardware loads the status word; no write path reaches it.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            status_reg <= ascal_pkg::STATUS_RST;
        else
            status_reg <= status_next;
    end

    // ============================================================
    // Conversion sequencer
    // ============================================================
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            conv_busy_reg <= 1'b0;
            conv_cnt_reg  <= 8'h00;
            result_reg    <= 12'h000;
        end
        else if (!conv_busy_reg && ctrl_wr && wr_ctrl.conv_go)
        begin
            conv_busy_reg <= 1'b1;
            conv_cnt_reg  <= 8'h00;
        end
        else if (conv_done)
        begin
            conv_busy_reg <= 1'b0;
            result_reg    <= conv_data;
        end
        else if (conv_busy_reg)
            conv_cnt_reg <= conv_cnt_reg + 8'h01;
    end

    // ============================================================
    // Calibration sequencer
    // ============================================================
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            cal_state_reg <= ASCAL_IDLE;
            cal_set_reg   <= ascal_pkg::CALSEL_ALL;
            cal_idx_reg   <= ascal_pkg::IDX_GAIN;
            cal_cnt_reg   <= 8'h00;
        end
        else
        begin
            case (cal_state_reg)
                ASCAL_IDLE:
                begin
                    if (ctrl_wr && wr_ctrl.cal_go)
                    begin
                        cal_state_reg <= ASCAL_RUN;
                        cal_set_reg   <= wr_ctrl.cal_select;
                        cal_idx_reg   <= ptr_start(wr_ctrl.cal_select);
                        cal_cnt_reg   <= 8'h00;
                    end
                end
                ASCAL_RUN:
                begin
                    if (cal_end)
                        cal_state_reg <= ASCAL_IDLE;
                    else if (cal_step)
                    begin
                        cal_idx_reg <= ptr_step(cal_idx_reg, cal_set_reg);
                        cal_cnt_reg <= 8'h00;
                    end
                    else
                        cal_cnt_reg <= cal_cnt_reg + 8'h01;
                end
                default:
                    cal_state_reg <= ASCAL_IDLE;
            endcase
        end
    end

    // ============================================================
    // Coefficient store
    // ============================================================
    // Host writes are ignored while a calibration run owns the registers.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < ascal_pkg::NUM_COEF; i++)
                coef_reg[i] <= ascal_pkg::DAC_RST;
            coef_reg[ascal_pkg::IDX_GAIN] <= ascal_pkg::GAIN_RST;
            coef_reg[ascal_pkg::IDX_OFS]  <= ascal_pkg::OFS_RST;
        end
        else if (cal_step)
            coef_reg[cal_idx_reg] <= cal_cov_fix(cal_coef_in);
        else if (cal_wr)
            coef_reg[ptr_reg] <= req.wdata[13:0];
    end

    // ============================================================
    // Access pointer
    // ============================================================
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            addr_sel_reg <= ascal_pkg::CALSEL_ALL;
            ptr_reg      <= ascal_pkg::IDX_GAIN;
        end
        else if (ctrl_wr)
        begin
            if (!wr_ctrl.cal_go)
            begin
                addr_sel_reg <= wr_ctrl.cal_select;
                ptr_reg      <= ptr_start(wr_ctrl.cal_select);
            end
            else
                ptr_reg <= ptr_start(addr_sel_reg);
        end
        else if (cal_wr || cal_rd)
            ptr_reg <= ptr_step(ptr_reg, addr_sel_reg);
    end

    // ============================================================
    // Read data
    // ============================================================
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            rd_data_reg <= 16'h0000;
        else if (req.rd && req.addr == ascal_pkg::ADDR_CTRL_RB)
            rd_data_reg <= 16'(ctrl_reg);
        else if (req.rd)
        begin
            case (ctrl_reg.read_select)
                ascal_pkg::RDSEL_STATUS: rd_data_reg <= status_reg;
                ascal_pkg::RDSEL_CAL:    rd_data_reg <= {2'h0, coef_reg[ptr_reg]};
                default:                 rd_data_reg <= {4'h0, result_reg};
            endcase
        end
        else
            rd_data_reg <= 16'h0000;
    end

    assign rd_data         = rd_data_reg;
    assign busy            = status_reg[ascal_pkg::ST_BUSY];
    assign power_mgmt      = ctrl_reg.power_mgmt;
    assign input_range_sel = ctrl_reg.input_range_sel;
    assign gain_coef       = coef_reg[ascal_pkg::IDX_GAIN];
    assign offset_coef     = coef_reg[ascal_pkg::IDX_OFS];

    // ============================================================
    // Checks
    // ============================================================
    status_rst_a: assert property (@(posedge clk_sys) sys_rst |=> status_reg == 16'h0000)
        else $error("status word not cleared by reset");

    status_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        status_reg[15:10] == 6'h00)
        else $error("status high bits not zero");

    status_ones_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !$past(sys_rst) |-> status_reg[7:6] == 2'h3)
        else $error("status bits 7 and 6 not one");

    status_echo_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ctrl_wr ##1 1'b1 |=> status_reg[9:8] == $past(wr_ctrl.power_mgmt, 2)
                             && status_reg[5] == $past(wr_ctrl.input_range_sel, 2)
                             && status_reg[3] == $past(wr_ctrl.cal_kind_sel, 2)
                             && status_reg[2:1] == $past(wr_ctrl.cal_select, 2))
        else $error("status does not echo control fields");

    busy_bit_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (ctrl_wr && wr_ctrl.conv_go && !conv_busy_reg) |=> ##1 status_reg[4])
        else $error("busy bit not set during conversion");

    busy_idle_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!conv_busy_reg && !cal_busy) |=> !status_reg[ascal_pkg::ST_BUSY])
        else $error("busy bit set with nothing running");

    cal_refuse_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (req.wr && req.addr == ascal_pkg::ADDR_CAL_WR && cal_busy)
        |=> ptr_reg == $past(ptr_reg))
        else $error("host coefficient write taken during calibration");

    sel_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (ctrl_wr && wr_ctrl.cal_go) |=> addr_sel_reg == $past(addr_sel_reg))
        else $error("access select changed by calibration start");

    full_order_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ((cal_wr || cal_rd) && addr_sel_reg == ascal_pkg::CALSEL_ALL
         && ptr_reg == ascal_pkg::IDX_GAIN) |=> ptr_reg == ascal_pkg::IDX_OFS)
        else $error("offset does not follow gain in full sequence");

    cal_bit_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cal_end |=> ##1 !status_reg[0])
        else $error("calibration bit not cleared at end");

    cal_load_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cal_step |=> coef_reg[$past(cal_idx_reg)] == $past(cal_coef_in))
        else $error("calibration run did not load coefficient");

    ptr_reset_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (ctrl_wr && !wr_ctrl.cal_go && wr_ctrl.cal_select == ascal_pkg::CALSEL_OFS)
        |=> ptr_reg == ascal_pkg::IDX_OFS)
        else $error("pointer not at offset for offset-only select");

    ptr_adv_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (cal_wr && addr_sel_reg == ascal_pkg::CALSEL_ALL && ptr_reg != ascal_pkg::IDX_DAC_LAST)
        |=> ptr_reg == $past(ptr_reg) + 4'h1)
        else $error("pointer did not advance");

    ptr_wrap_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ((cal_wr || cal_rd) && ptr_reg == ptr_last(addr_sel_reg) && !ctrl_wr)
        |=> ptr_reg == ptr_start(addr_sel_reg))
        else $error("pointer did not restart after last access");

    cal_lead_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cal_rd |=> rd_data[15:14] == 2'h0 && rd_data[13:0] == coef_reg[$past(ptr_reg)])
        else $error("coefficient read malformed");

    status_rd_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (req.rd && req.addr == ascal_pkg::ADDR_CTRL
         && ctrl_reg.read_select == ascal_pkg::RDSEL_STATUS)
        |=> rd_data == $past(status_reg))
        else $error("status read returned wrong value");

    full_cal_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        cal_end && cal_set_reg == ascal_pkg::CALSEL_ALL);
    cal_seq_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        cal_rd && ptr_reg == ascal_pkg::IDX_DAC_LAST);
    status_rd_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        req.rd && ctrl_reg.read_select == ascal_pkg::RDSEL_STATUS && status_reg[4]);
    conv_c: cover property (@(posedge clk_sys) disable iff (sys_rst) conv_done);

endmodule
